/* File: pkg/bst_pkg.sv */
// Shared constants and types for the boundary-scan test port
package bst_pkg;

   // ----------------------------------------
   // Register widths
   // ----------------------------------------
   localparam int IR_W = 3;
   localparam int ID_W = 32;
   localparam int BSR_W = 48;

   // ----------------------------------------
   // Instruction codes
   // ----------------------------------------
   localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
   localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

   // Fixed pattern loaded into the low two bits on instruction capture
   localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
   localparam logic IR_CAPTURE_HIGH = 1'b0;

   // Identification word; value is arbitrary
   localparam logic [ID_W-1:0] ID_WORD = 32'h0000_1001;

   // Reset values
   localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;
   localparam logic BYPASS_RESET = 1'b0;
   localparam logic [BSR_W-1:0] BSR_RESET = 48'h0000_0000_0000;
   localparam logic TDO_RESET = 1'b0;
   localparam logic TDO_OE_N_RESET = 1'b1;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_RESET,
      ST_IDLE,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPD_IR
   } bst_state_t;

   // Controls handed from the test logic to the memory side
   typedef struct packed {
      logic out_highz;
      logic extest;
   } bst_ctl_t;

   localparam int CTL_W = $bits(bst_ctl_t);

endpackage : bst_pkg

/* File: verilog/bst_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/100ps

module bst_sync #(
   parameter int W = 1
) (
   input wire logic clk, // Destination clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic [W-1:0] rst_val, // Value held during reset
   input wire logic [W-1:0] din, // Level from the other domain
   output logic [W-1:0] dout // Synchronised level
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ----------------------------------------
   // First stage feeds only the second
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= rst_val;
         sync_q <= rst_val;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule : bst_sync

/* File: verilog/bst_tap.sv */
// Boundary-scan test access port controller and its scan registers
//
// How it works
// RULE_01: Standard boundary-scan states, pins and register access.
// RULE_02: Test clock drives only test logic.
// RULE_03: Inputs sampled on rising test clock edge.
// RULE_04: Outputs change only on falling edge.
// RULE_05: Unused port keeps test clock low.
// RULE_06: Mode select and data in pulled high.
// RULE_07: Unused port leaves data out open.
// RULE_08: Power-up starts in reset, memory undisturbed; here the port resets only if the test clock runs during memory reset.
// RULE_09: Instruction selects the one scan register.
// RULE_10: Serial data enters the MSB.
// RULE_11: Serial output shows the LSB.
// RULE_12: Output driver enabled only while shifting.
// RULE_13: Five high mode-select edges reset test logic.
// RULE_14: Three-bit instruction register loaded serially.
// RULE_15: Instruction capture loads 01 in low bits.
// RULE_16: Sixteen-state machine; reset state floats output.
`timescale 1ns/100ps

module bst_tap (
   input wire logic clk, // Memory clock, 250 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic tck, // Test clock from the pin
   input wire logic tms, // Mode select pin level
   input wire logic tms_float, // Mode select pin left open
   input wire logic tdi, // Serial data in pin level
   input wire logic tdi_float, // Serial data in pin left open
   input wire logic [bst_pkg::BSR_W-1:0] ring_pins, // Pin ring sampled on capture
   output logic tdo, // Serial data out
   output logic tdo_oe_n, // Serial out enable, low drives
   output logic [bst_pkg::BSR_W-1:0] bsr_preload, // Latched boundary pattern, test clock domain
   output bst_pkg::bst_ctl_t mem_ctl // Test controls in the memory clock domain
);

   bst_pkg::bst_state_t state_q;
   bst_pkg::bst_state_t state_d;
   logic rst_tck;
   logic tms_eff;
   logic tdi_eff;
   logic [bst_pkg::IR_W-1:0] ir_sh_q;
   logic [bst_pkg::IR_W-1:0] ir_q;
   logic bypass_q;
   logic [bst_pkg::ID_W-1:0] id_q;
   logic [bst_pkg::BSR_W-1:0] bsr_q;
   logic [bst_pkg::BSR_W-1:0] ring_s;
   logic [bst_pkg::BSR_W-1:0] preload_q;
   logic tdo_q;
   logic tdo_oe_n_q;
   logic sel_bit;
   bst_pkg::bst_ctl_t ctl_q;

   // ----------------------------------------
   // Reset and pin conditioning
   // ----------------------------------------
   // RULE_08 power-up reset
   // Memory reset crosses in on the test clock, so the port starts in its reset state only if the test clock runs during reset
   bst_sync #(.W(1)) u_rst_sync (
      .clk(tck),
      .rst(1'b0),
      .rst_val(1'b1),
      .din(rst),
      .dout(rst_tck)
   );

   // RULE_06 pull-up emulation
   // An open pin reads high, as the internal pull-up would give
   assign tms_eff = tms | tms_float;
   assign tdi_eff = tdi | tdi_float;

   // Ring snapshot crosses into the test clock; values in motion are not guaranteed
   bst_sync #(.W(bst_pkg::BSR_W)) u_ring_sync (
      .clk(tck),
      .rst(rst_tck),
      .rst_val(bst_pkg::BSR_RESET),
      .din(ring_pins),
      .dout(ring_s)
   );

   // ----------------------------------------
   // Controller state machine
   // ----------------------------------------
   // RULE_01 standard controller walk
   // RULE_16 sixteen-state transitions
   // RULE_13 five high edges always reach reset
   always_comb begin
      state_d = state_q;
      case (state_q)
         bst_pkg::ST_RESET: state_d = tms_eff ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE: state_d = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR: state_d = tms_eff ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: state_d = tms_eff ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_SHIFT_DR: state_d = tms_eff ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_EXIT1_DR: state_d = tms_eff ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_PAUSE_DR: state_d = tms_eff ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_EXIT2_DR: state_d = tms_eff ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_UPD_DR: state_d = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR: state_d = tms_eff ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: state_d = tms_eff ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_SHIFT_IR: state_d = tms_eff ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_EXIT1_IR: state_d = tms_eff ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_PAUSE_IR: state_d = tms_eff ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_EXIT2_IR: state_d = tms_eff ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_UPD_IR: state_d = tms_eff ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         default: state_d = bst_pkg::ST_RESET;
      endcase
   end

   // RULE_03 inputs taken on rising edge
   // RULE_02 only test logic on this clock
   always_ff @(posedge tck) begin
      if (rst_tck) begin
         state_q <= bst_pkg::ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------
   // RULE_14 three-bit serial instruction load
   always_ff @(posedge tck) begin
      if (rst_tck || state_q == bst_pkg::ST_RESET) begin
         ir_sh_q <= bst_pkg::IR_RESET;
         ir_q <= bst_pkg::IR_RESET;
      end else begin
         case (state_q)
            // RULE_15 fixed capture pattern
            bst_pkg::ST_CAP_IR: ir_sh_q <= {bst_pkg::IR_CAPTURE_HIGH, bst_pkg::IR_CAPTURE_LOW};
            // RULE_10 data in at MSB
            bst_pkg::ST_SHIFT_IR: ir_sh_q <= {tdi_eff, ir_sh_q[bst_pkg::IR_W-1:1]};
            bst_pkg::ST_UPD_IR: ir_q <= ir_sh_q;
            default: ir_q <= ir_q;
         endcase
      end
   end

   // ----------------------------------------
   // Data registers
   // ----------------------------------------
   // RULE_09 capture and shift only the selected register
   always_ff @(posedge tck) begin
      if (rst_tck) begin
         bypass_q <= bst_pkg::BYPASS_RESET;
         id_q <= bst_pkg::ID_WORD;
         bsr_q <= bst_pkg::BSR_RESET;
      end else if (state_q == bst_pkg::ST_CAP_DR) begin
         case (ir_q)
            bst_pkg::INS_IDCODE: id_q <= bst_pkg::ID_WORD;
            bst_pkg::INS_EXTEST, bst_pkg::INS_SAMPLE, bst_pkg::INS_SAMPLE_Z: bsr_q <= ring_s;
            default: bypass_q <= bst_pkg::BYPASS_RESET;
         endcase
      end else if (state_q == bst_pkg::ST_SHIFT_DR) begin
         // RULE_10 data in at MSB of selected register
         case (ir_q)
            bst_pkg::INS_IDCODE: id_q <= {tdi_eff, id_q[bst_pkg::ID_W-1:1]};
            bst_pkg::INS_EXTEST, bst_pkg::INS_SAMPLE, bst_pkg::INS_SAMPLE_Z:
               bsr_q <= {tdi_eff, bsr_q[bst_pkg::BSR_W-1:1]};
            default: bypass_q <= tdi_eff;
         endcase
      end
   end

   // Preload latch follows the shift stage on update only
   always_ff @(posedge tck) begin
      if (rst_tck) begin
         preload_q <= bst_pkg::BSR_RESET;
      end else if (state_q == bst_pkg::ST_UPD_DR && (ir_q == bst_pkg::INS_EXTEST || ir_q == bst_pkg::INS_SAMPLE)) begin
         preload_q <= bsr_q;
      end
   end

   assign bsr_preload = preload_q;

   // ----------------------------------------
   // Serial output, falling edge
   // ----------------------------------------
   // RULE_11 lowest bit of the selected path
   always_comb begin
      sel_bit = bypass_q;
      if (state_q == bst_pkg::ST_SHIFT_IR) begin
         sel_bit = ir_sh_q[0];
      end else begin
         case (ir_q)
            bst_pkg::INS_IDCODE: sel_bit = id_q[0];
            bst_pkg::INS_EXTEST, bst_pkg::INS_SAMPLE, bst_pkg::INS_SAMPLE_Z: sel_bit = bsr_q[0];
            default: sel_bit = bypass_q;
         endcase
      end
   end

   // RULE_04 outputs move on falling edge
   // RULE_12 driver on only in shift states
   // RULE_16 reset keeps output floating
   always_ff @(negedge tck) begin
      if (rst_tck) begin
         tdo_q <= bst_pkg::TDO_RESET;
         tdo_oe_n_q <= bst_pkg::TDO_OE_N_RESET;
      end else begin
         tdo_q <= sel_bit;
         tdo_oe_n_q <= !(state_q == bst_pkg::ST_SHIFT_DR || state_q == bst_pkg::ST_SHIFT_IR);
      end
   end

   assign tdo = tdo_q;
   assign tdo_oe_n = tdo_oe_n_q;

   // ----------------------------------------
   // Controls toward the memory
   // ----------------------------------------
   // Levels only, so a two-flop crossing is enough; the test clock may stop
   always_ff @(posedge tck) begin
      if (rst_tck) begin
         ctl_q <= '0;
      end else begin
         ctl_q.out_highz <= (ir_q == bst_pkg::INS_SAMPLE_Z);
         ctl_q.extest <= (ir_q == bst_pkg::INS_EXTEST);
      end
   end

   // RULE_08 reset leaves memory in normal operation
   bst_sync #(.W(bst_pkg::CTL_W)) u_ctl_sync (
      .clk(clk),
      .rst(rst),
      .rst_val('0),
      .din(ctl_q),
      .dout(mem_ctl)
   );

endmodule : bst_tap

/* File: testbench/bst_jtag_host.sv */
// Board-side test controller model for the test port
`timescale 1ns/100ps

module bst_jtag_host (
   output logic tck, // Test clock, still between scans
   output logic tms, // Mode select
   output logic tdi, // Serial data in
   input wire logic tdo // Serial data out, never driven here
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   task automatic step(input logic m, input logic d, output logic s);
      tms = m;
      tdi = d;
      #15 s = tdo;
      tck = 1'b1;
      #15 tck = 1'b0;
   endtask : step

   task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic s;
      dout = '0;
      step(1'b1, 1'b1, s);
      if (ir) step(1'b1, 1'b1, s);
      step(1'b0, 1'b1, s);
      step(1'b0, 1'b1, s);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], s);
         dout[i] = s;
      end
      step(1'b1, 1'b1, s);
      step(1'b0, 1'b1, s);
   endtask : scan
endmodule : bst_jtag_host

/* File: testbench/bst_tap_checker.sv */
// Pin-level timing checks for the test port
`timescale 1ns/100ps

module bst_tap_checker (
   input wire logic clk, // Memory clock
   input wire logic rst, // Synchronous reset
   input wire logic tck, // Test clock
   input wire logic tms, // Mode select
   input wire logic tms_float, // Mode select open
   input wire logic tdo, // Serial out
   input wire logic tdo_oe_n, // Serial out enable, low drives
   input wire bst_pkg::bst_ctl_t mem_ctl // Memory side controls
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Open pin reads high
   wire logic tms_eff = tms | tms_float;
   logic [3:0] quiet_q;

   // Memory cycles since test clock was last high
   always_ff @(posedge clk) begin
      if (rst || tck) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_tdo_fall_edge: assert property (@(tdo) disable iff (rst) tck)
      else $error("serial out moved off a falling edge");
   chk_oe_fall_edge: assert property (@(tdo_oe_n) disable iff (rst) tck)
      else $error("output enable moved off a falling edge");
   chk_five_high: assert property (@(posedge tck) disable iff (rst) tms_eff [*5] |=> tdo_oe_n)
      else $error("driver on after five high mode bits");
   chk_shift_entry: assert property (@(posedge tck) disable iff (rst) !tdo_oe_n |-> !$past(tms_eff))
      else $error("driver on without a low mode bit");
   chk_shift_exit: assert property (@(posedge tck) disable iff (rst) !tdo_oe_n && tms_eff |=> tdo_oe_n)
      else $error("driver still on after leaving shift");
   chk_ctl_reset: assert property (@(posedge clk) rst ##1 rst |=> mem_ctl == '0)
      else $error("memory controls not cleared by reset");
   chk_ctl_exclusive: assert property (@(posedge clk) disable iff (rst) !(mem_ctl.out_highz && mem_ctl.extest))
      else $error("two instructions active at once");
   chk_ctl_tck_only: assert property (@(posedge clk) disable iff (rst) quiet_q >= 4'h8 |-> $stable(mem_ctl))
      else $error("memory controls moved with test clock stopped");
endmodule : bst_tap_checker

bind bst_tap bst_tap_checker i_bst_tap_checker (.clk, .rst, .tck, .tms, .tms_float, .tdo, .tdo_oe_n, .mem_ctl);

/* File: testbench/bst_tap_tb_top.sv */
// Self-checking bench for the test port
`timescale 1ns/100ps

module bst_tap_tb_top;
   localparam logic [47:0] RING = 48'hA5C3_0F96_1E2D;
   localparam logic [63:0] PAT = 64'h0000_3C5A_9617_E0D4;
   logic clk, rst, tms_float, tdi_float, tck, tms, tdi, tdo, tdo_oe_n, q;
   logic [bst_pkg::BSR_W-1:0] bsr_preload;
   bst_pkg::bst_ctl_t mem_ctl;
   logic [63:0] o;
   logic [2:0] cap;
   int fail_count, cmp_count;

   // Memory clock, 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Released line shows the inverse, so a sample outside the driven window is caught
   logic tdo_line;
   assign tdo_line = tdo_oe_n ? ~tdo : tdo;

   bst_jtag_host i_bst_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
   bst_tap i_bst_tap (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tms_float(tms_float), .tdi(tdi),
      .tdi_float(tdi_float), .ring_pins(RING), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .bsr_preload(bsr_preload), .mem_ctl(mem_ctl));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude

   task automatic ir(input logic [2:0] code);
      i_bst_jtag_host.scan(1'b1, 3, {61'h0, code}, o);
      cap = o[2:0];
      // Controls follow the instruction one test clock later, so give one idle edge
      i_bst_jtag_host.step(1'b0, 1'b1, q);
   endtask : ir

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Reset needs test clock edges, so it is held over four of them
   task automatic t_reset();
      repeat (4) i_bst_jtag_host.step(1'b1, 1'b1, q);
      @(posedge clk) rst <= 1'b0;
      check(64'(tdo_oe_n), 64'h1, "oe after reset");
      check(64'(mem_ctl), 64'h0, "ctl after reset");
      repeat (2) i_bst_jtag_host.step(1'b1, 1'b1, q);
      i_bst_jtag_host.step(1'b0, 1'b1, q);
      i_bst_jtag_host.scan(1'b0, 32, 64'h0, o);
      check(o, {32'h0, bst_pkg::ID_WORD}, "id word");
      $display("reset test done");
   endtask : t_reset

   // Bypass and reserved codes give a one-bit path
   task automatic t_bypass();
      logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
      foreach (codes[i]) begin
         ir(codes[i]);
         check(64'(cap), 64'({bst_pkg::IR_CAPTURE_HIGH, bst_pkg::IR_CAPTURE_LOW}), "ir capture");
         i_bst_jtag_host.scan(1'b0, 4, 64'hB, o);
         check(o, 64'h6, "bypass path");
      end
      $display("bypass test done");
   endtask : t_bypass

   task automatic t_ctl();
      ir(bst_pkg::INS_SAMPLE_Z);
      repeat (8) @(posedge clk);
      check(64'(mem_ctl), 64'h2, "float ctl");
      // Float instruction captures the ring but leaves the latch alone
      i_bst_jtag_host.scan(1'b0, 48, PAT, o);
      check(o, {16'h0, RING}, "float capture");
      check(64'(bsr_preload), 64'h0, "float preload");
      ir(bst_pkg::INS_EXTEST);
      repeat (8) @(posedge clk);
      check(64'(mem_ctl), 64'h1, "extest ctl");
      i_bst_jtag_host.scan(1'b0, 48, {16'h0, RING}, o);
      check(o, {16'h0, RING}, "extest capture");
      check(64'(bsr_preload), {16'h0, RING}, "extest preload");
      $display("control test done");
   endtask : t_ctl

   task automatic t_bsr();
      ir(bst_pkg::INS_SAMPLE);
      i_bst_jtag_host.scan(1'b0, 48, PAT, o);
      check(o, {16'h0, RING}, "ring capture");
      check(64'(bsr_preload), PAT, "preload");
      $display("boundary test done");
   endtask : t_bsr

   // Open pins read high: data in fills ones, mode select resets
   task automatic t_pullup();
      ir(bst_pkg::INS_BYPASS);
      @(posedge clk) tdi_float <= 1'b1;
      i_bst_jtag_host.scan(1'b0, 4, 64'h0, o);
      check(o, 64'hE, "open data in");
      @(posedge clk) tdi_float <= 1'b0;
      tms_float <= 1'b1;
      repeat (5) i_bst_jtag_host.step(1'b0, 1'b1, q);
      @(posedge clk) tms_float <= 1'b0;
      i_bst_jtag_host.step(1'b0, 1'b1, q);
      i_bst_jtag_host.scan(1'b0, 32, 64'h0, o);
      check(o, {32'h0, bst_pkg::ID_WORD}, "id after tms reset");
      $display("pull-up test done");
   endtask : t_pullup

   // Watchdog, far beyond the expected 11 us
   initial begin
      #50us;
      fail_count++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      tms_float = 1'b0;
      tdi_float = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      t_reset();
      t_bypass();
      t_ctl();
      t_bsr();
      t_pullup();
      conclude();
   end
endmodule : bst_tap_tb_top
